// >>> design/smbus_lamp_control_slave.sv
// Contract
// - Strap high turns shared pins into serial bus
// - Write, read, send and receive byte supported
// - Slave only, answers address 0x2D
// - Brightness 5 bits, mode 3, status 2
// - Chip, revision and maker identity bytes
// - Data changes only while clock low
// - Eight-bit words, sampled on clock rise
// - Nine clocks per byte, receiver acknowledges
// - Write address expects one or two bytes
// - Early start or stop discards everything
// - Writes take effect at stop or restart
// - Read address returns selected register
// - Write byte: address, command, data, stop
// - Read byte: command, restart, read, nack
// - Send byte: address and command only
// - Receive byte uses last command
// - Write 0, read 1, ack 0, nack 1
// - Serial side works during lamp shutdown
// - Brightness code 0 minimum, 31 maximum
`default_nettype none
module smbus_lamp_control_slave import lamp_smbus_pkg::*; (
	input wire logic clock, // System clock, 25 MHz
	input wire logic rstn, // Synchronous reset, active low
	input wire logic link_clock, // Sampling clock of the link side
	input wire logic mode_strap, // Strap pin, high selects serial mode
	input wire logic level_ctl_or_serial_clock_pin, // Serial clock pin
	input wire logic fullscale_ref_or_serial_data_pin_in, // Data pin level
	output logic fullscale_ref_or_serial_data_pin_out, // Data pin drive value
	output logic fullscale_ref_or_serial_data_pin_oe_n, // Data pin enable, low drives
	input wire logic [1:0] fault_status_bits, // Fault status from the lamp logic
	output logic [4:0] brightness_code, // Brightness register
	output logic [2:0] shutdown_mode_bits // Shutdown mode register
);
	// Link side reset, taken over from the system reset
	logic link_rst_n; // Synchronised rstn in the link domain

	level_sync #(.WIDTH(1)) u_rst_sync (
		.clock(link_clock),
		.d(rstn),
		.q(link_rst_n)
	);

	// Pins and status enter the link domain through two flops
	logic [4:0] pins_s; // Synchronised strap, clock, data, status
	logic strap_s; // Serial mode selected
	logic scl_s; // Clock line level
	logic sda_s; // Data line level
	logic [1:0] status_s; // Fault status for reads

	level_sync #(.WIDTH(5)) u_pin_sync (
		.clock(link_clock),
		.d({mode_strap, level_ctl_or_serial_clock_pin, fullscale_ref_or_serial_data_pin_in,
			fault_status_bits}),
		.q(pins_s)
	);

	assign strap_s = pins_s[4];
	assign scl_s = pins_s[3];
	assign sda_s = pins_s[2];
	assign status_s = pins_s[1:0];

	// Link engine state
	link_state_t state_q; // Current protocol phase
	link_state_t state_d; // Next protocol phase
	logic scl_p; // Clock level one sample ago
	logic sda_p; // Data level one sample ago
	logic [7:0] sh_q; // Receive shifter
	logic [7:0] sh_d; // Next receive shifter
	logic [7:0] tx_q; // Transmit shifter
	logic [7:0] tx_d; // Next transmit shifter
	logic [2:0] cnt_q; // Bit counter within a byte
	logic [2:0] cnt_d; // Next bit counter
	logic bdone_q; // Eight bits in, waiting for the fall
	logic bdone_d; // Next byte done flag
	logic oe_n_q; // Data pin enable, low drives low
	logic oe_n_d; // Next data pin enable
	logic rw_q; // Direction bit of the last address byte, own or foreign
	logic [7:0] cmd_q; // Command byte of this transaction
	logic [7:0] ptr_q; // Command byte kept by the last write or send byte
	logic [4:0] bright_sh_q; // Link copy of brightness for reads
	logic [2:0] shdn_sh_q; // Link copy of shutdown mode for reads
	logic commit_tgl_q; // Flips once per completed write
	reg_sel_t wr_sel_q; // View written by the last commit
	logic [7:0] wr_data_q; // Data of the last commit

	// Edge and condition decoding on the sampled lines
	wire rise_w = scl_s & ~scl_p;
	wire fall_w = ~scl_s & scl_p;
	wire start_w = scl_s & scl_p & sda_p & ~sda_s;
	wire stop_w = scl_s & scl_p & ~sda_p & sda_s;
	wire frame_w = strap_s & (start_w | stop_w);
	wire rx_state_w = (state_q == ST_ADDR) | (state_q == ST_CMD) | (state_q == ST_DATA);
	wire addr_hit_w = (sh_q[7:1] == OWN_ADDR);
	wire byte_end_w = fall_w & bdone_q;
	// The clock rise of a stop or restart is sampled like a bit, so one bit means no data came
	wire data_empty_w = (state_q == ST_DATA) & (cnt_q == 3'h1) & ~bdone_q;
	// Write byte complete: data acknowledged, then stop or restart
	wire commit_w = frame_w & (state_q == ST_DONE);
	// Send byte or first half of read byte: command alone is kept
	wire ptr_load_w = commit_w | (frame_w & data_empty_w);
	wire reg_sel_t ptr_sel_w = reg_select(ptr_q);
	wire [7:0] tx_byte_w = read_byte(ptr_sel_w, bright_sh_q, shdn_sh_q, status_s);

	// Next-state and shifter logic
	always_comb begin
		state_d = state_q;
		sh_d = sh_q;
		tx_d = tx_q;
		cnt_d = cnt_q;
		bdone_d = bdone_q;
		oe_n_d = oe_n_q;
		if (!strap_s) begin
			// Analog mode: pins belong to the lamp logic
			state_d = ST_IDLE;
			oe_n_d = 1'h1;
			cnt_d = 3'h0;
			bdone_d = 1'h0;
		end else if (start_w) begin
			// Start or restart: any partial byte is dropped
			state_d = ST_ADDR;
			oe_n_d = 1'h1;
			cnt_d = 3'h0;
			bdone_d = 1'h0;
		end else if (stop_w) begin
			// Bus free again
			state_d = ST_IDLE;
			oe_n_d = 1'h1;
			cnt_d = 3'h0;
			bdone_d = 1'h0;
		end else begin
			// Receive: sample on the rising clock, first bit lands in bit 7
			if (rise_w && rx_state_w && !bdone_q) begin
				sh_d = {sh_q[6:0], sda_s};
				cnt_d = cnt_q + 3'h1;
				bdone_d = (cnt_q == LAST_BIT);
			end
			unique case (state_q)
				ST_IDLE: begin
					// Wait for a start
				end
				ST_IGNORE: begin
					// Line stays released until the next frame
				end
				ST_ADDR: begin
					if (byte_end_w) begin
						bdone_d = 1'h0;
						if (addr_hit_w) begin
							state_d = ST_ADDR_ACK;
							oe_n_d = ACK_BIT;
						end else begin
							state_d = ST_IGNORE;
						end
					end
				end
				ST_CMD: begin
					if (byte_end_w) begin
						bdone_d = 1'h0;
						state_d = ST_CMD_ACK;
						oe_n_d = ACK_BIT;
					end
				end
				ST_DATA: begin
					if (byte_end_w) begin
						bdone_d = 1'h0;
						state_d = ST_DATA_ACK;
						oe_n_d = ACK_BIT;
					end
				end
				ST_ADDR_ACK: begin
					if (fall_w) begin
						if (rw_q == RW_READ) begin
							// Drive the first data bit as the ack clock ends
							state_d = ST_TX;
							tx_d = tx_byte_w;
							oe_n_d = tx_byte_w[7];
							cnt_d = 3'h0;
						end else begin
							state_d = ST_CMD;
							oe_n_d = 1'h1;
						end
					end
				end
				ST_CMD_ACK: begin
					if (fall_w) begin
						state_d = ST_DATA;
						oe_n_d = 1'h1;
					end
				end
				ST_DATA_ACK: begin
					if (fall_w) begin
						state_d = ST_DONE;
						oe_n_d = 1'h1;
					end
				end
				ST_DONE: begin
					// A stop clock only rises; a full extra clock breaks the format and drops the write
					if (fall_w) state_d = ST_IGNORE;
				end
				ST_TX: begin
					// Change the line only after the clock has fallen
					if (fall_w) begin
						cnt_d = cnt_q + 3'h1;
						if (cnt_q == LAST_BIT) begin
							state_d = ST_TX_ACK;
							oe_n_d = 1'h1;
						end else begin
							tx_d = {tx_q[6:0], 1'h1};
							oe_n_d = tx_q[6];
						end
					end
				end
				ST_TX_ACK: begin
					// Master nack ends the read; ack repeats the same view
					if (rise_w && sda_s == NACK_BIT) begin
						state_d = ST_IGNORE;
					end else if (fall_w) begin
						state_d = ST_TX;
						tx_d = tx_byte_w;
						oe_n_d = tx_byte_w[7];
						cnt_d = 3'h0;
					end
				end
				default: begin
					// Illegal code: return to idle with the line released
					state_d = ST_IDLE;
					oe_n_d = 1'h1;
				end
			endcase
		end
	end

	// Engine registers
	always_ff @(posedge link_clock) begin
		if (!link_rst_n) begin
			state_q <= ST_IDLE;
			scl_p <= 1'h1;
			sda_p <= 1'h1;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			cnt_q <= 3'h0;
			bdone_q <= 1'h0;
			oe_n_q <= 1'h1;
			fullscale_ref_or_serial_data_pin_out <= 1'h0;
		end else begin
			state_q <= state_d;
			scl_p <= scl_s;
			sda_p <= sda_s;
			sh_q <= sh_d;
			tx_q <= tx_d;
			cnt_q <= cnt_d;
			bdone_q <= bdone_d;
			oe_n_q <= oe_n_d;
			fullscale_ref_or_serial_data_pin_out <= 1'h0;
		end
	end

	assign fullscale_ref_or_serial_data_pin_oe_n = oe_n_q;

	// Captured transaction fields
	always_ff @(posedge link_clock) begin
		if (!link_rst_n) begin
			rw_q <= RW_WRITE;
			cmd_q <= 8'h00;
		end else begin
			if (state_q == ST_ADDR && byte_end_w && strap_s && !frame_w) rw_q <= sh_q[0];
			if (state_q == ST_CMD && byte_end_w && strap_s && !frame_w) cmd_q <= sh_q;
		end
	end

	// Commit point: only a finished transaction reaches the registers.
	// Shadows and pointer move together, so a read after restart sees the write.
	always_ff @(posedge link_clock) begin
		if (!link_rst_n) begin
			ptr_q <= PTR_RST;
			bright_sh_q <= BRIGHT_RST;
			shdn_sh_q <= SHDN_RST;
			commit_tgl_q <= 1'h0;
			wr_sel_q <= SEL_NONE;
			wr_data_q <= 8'h00;
		end else begin
			if (ptr_load_w) ptr_q <= cmd_q;
			if (commit_w) begin
				commit_tgl_q <= ~commit_tgl_q;
				wr_sel_q <= reg_select(cmd_q);
				wr_data_q <= sh_q;
				bright_sh_q <= next_bright(reg_select(cmd_q), sh_q, bright_sh_q);
				shdn_sh_q <= next_shdn(reg_select(cmd_q), sh_q, shdn_sh_q);
			end
		end
	end

	// Commit toggle crosses to the system clock; fields are held meanwhile
	logic commit_tgl_s; // Toggle in the system domain

	level_sync #(.WIDTH(1)) u_commit_sync (
		.clock(clock),
		.d(commit_tgl_q),
		.q(commit_tgl_s)
	);

	// Register bank runs on the system clock, independent of lamp shutdown
	lamp_reg_bank u_regs (
		.clock(clock),
		.rstn(rstn),
		.commit_tgl_s(commit_tgl_s),
		.wr_sel(wr_sel_q),
		.wr_data(wr_data_q),
		.brightness_code(brightness_code),
		.shutdown_mode_bits(shutdown_mode_bits)
	);

	// Checks on the link side
	default clocking cb @(posedge link_clock); endclocking
	default disable iff (!link_rst_n);

	line_change_a: assert property (
		$changed(oe_n_q) && $past(strap_s) && !$past(start_w) && !$past(stop_w) |-> !$past(scl_s))
		else $error("data line changed while clock high");
	foreign_addr_a: assert property (
		state_q == ST_ADDR && byte_end_w && strap_s && !frame_w && !addr_hit_w
		|=> state_q == ST_IGNORE && oe_n_q)
		else $error("foreign address not ignored");
	own_addr_a: assert property (
		state_q == ST_ADDR && byte_end_w && strap_s && !frame_w && addr_hit_w
		|=> state_q == ST_ADDR_ACK && oe_n_q == ACK_BIT)
		else $error("own address not acknowledged");
	cmd_ack_a: assert property (
		state_q == ST_CMD_ACK |-> oe_n_q == ACK_BIT)
		else $error("command byte not acknowledged");
	early_frame_a: assert property (
		frame_w && (state_q == ST_DATA) && (cnt_q != 3'h0 || bdone_q) |=> $stable(commit_tgl_q))
		else $error("partial transaction was committed");
	commit_frame_a: assert property (
		$changed(commit_tgl_q) |-> $past(frame_w) && $past(state_q) == ST_DONE)
		else $error("commit outside stop or restart");
	send_ptr_a: assert property (
		frame_w && data_empty_w |=> ptr_q == $past(cmd_q) && $stable(commit_tgl_q))
		else $error("send byte did not update pointer alone");
	tx_first_a: assert property (
		$rose(state_q == ST_TX) |-> tx_q == read_byte(reg_select(ptr_q), bright_sh_q, shdn_sh_q, status_s))
		else $error("read returned the wrong register");
	msb_first_a: assert property (
		$rose(state_q == ST_TX) |-> oe_n_q == tx_q[7])
		else $error("first transmitted bit is not bit 7");
	rise_sample_a: assert property (
		rise_w && rx_state_w && !bdone_q && strap_s && !start_w && !stop_w |=> sh_q[0] == $past(sda_s))
		else $error("bit not sampled on rising clock");
	strap_idle_a: assert property (
		!strap_s |=> state_q == ST_IDLE ##1 oe_n_q)
		else $error("serial engine active in analog mode");
endmodule
`default_nettype wire

// >>> design/lamp_smbus_pkg.sv
`default_nettype none
package lamp_smbus_pkg;
	// Bus encodings
	localparam logic [6:0] OWN_ADDR = 7'h2D;
	localparam logic RW_WRITE = 1'h0;
	localparam logic RW_READ = 1'h1;
	localparam logic ACK_BIT = 1'h0;
	localparam logic NACK_BIT = 1'h1;
	localparam logic [2:0] LAST_BIT = 3'h7;
	// Power-on register values
	localparam logic [4:0] BRIGHT_RST = 5'h17;
	localparam logic [2:0] SHDN_RST = 3'h1;
	// Power-on pointer selects the combined brightness/status view
	localparam logic [7:0] PTR_RST = 8'h80;
	// Identity bytes; values are arbitrary
	localparam logic [7:0] CHIP_ID = 8'hA5;
	localparam logic [7:0] CHIP_REV = 8'h01;
	localparam logic [7:0] MFG_ID = 8'h3C;
	// Field positions and fill values
	localparam int COMBO_BRIGHT_LSB = 3;
	localparam logic [2:0] MODE_FILL = 3'h7;
	localparam logic COMBO_FILL = 1'h1;

	// Register views reachable by a command byte
	typedef enum logic [2:0] {
		SEL_BRIGHT, SEL_MODE, SEL_CHIPID, SEL_REV, SEL_COMBO, SEL_MFG, SEL_NONE
	} reg_sel_t;

	// Link engine states, Gray along the write path
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h3,
		ST_CMD = 4'h2,
		ST_CMD_ACK = 4'h6,
		ST_DATA = 4'h7,
		ST_DATA_ACK = 4'h5,
		ST_DONE = 4'h4,
		ST_TX = 4'hC,
		ST_TX_ACK = 4'hD,
		ST_IGNORE = 4'hF
	} link_state_t;

	// Decode a command byte into a register view
	function automatic reg_sel_t reg_select(input logic [7:0] cmd);
		reg_sel_t sel;
		sel = SEL_NONE;
		if (!cmd[7]) begin
			unique case (cmd[1:0])
				2'h1: sel = SEL_BRIGHT;
				2'h2: sel = SEL_MODE;
				2'h3: sel = SEL_CHIPID;
				2'h0: sel = SEL_REV;
			endcase
		end else if (!cmd[6]) begin
			sel = cmd[1] ? SEL_NONE : SEL_COMBO;
		end else begin
			sel = cmd[0] ? SEL_CHIPID : SEL_MFG;
		end
		return sel;
	endfunction

	// Byte returned for a register view
	function automatic logic [7:0] read_byte(input reg_sel_t sel, input logic [4:0] bright,
		input logic [2:0] shdn, input logic [1:0] status);
		logic [7:0] b;
		b = 8'h00;
		unique case (sel)
			SEL_BRIGHT: b = {3'h0, bright};
			SEL_MODE: b = {status, MODE_FILL, shdn};
			SEL_CHIPID: b = CHIP_ID;
			SEL_REV: b = CHIP_REV;
			SEL_COMBO: b = {bright, COMBO_FILL, status};
			SEL_MFG: b = MFG_ID;
			SEL_NONE: b = 8'h00;
		endcase
		return b;
	endfunction

	// Brightness after a write; other views leave it alone
	function automatic logic [4:0] next_bright(input reg_sel_t sel, input logic [7:0] data,
		input logic [4:0] cur);
		logic [4:0] n;
		n = cur;
		if (sel == SEL_BRIGHT) n = data[4:0];
		else if (sel == SEL_COMBO) n = data[COMBO_BRIGHT_LSB +: 5];
		return n;
	endfunction

	// Shutdown mode after a write; status bits are read-only
	function automatic logic [2:0] next_shdn(input reg_sel_t sel, input logic [7:0] data,
		input logic [2:0] cur);
		logic [2:0] n;
		n = cur;
		if (sel == SEL_MODE) n = data[2:0];
		return n;
	endfunction
endpackage
`default_nettype wire

// >>> design/level_sync.sv
`default_nettype none
module level_sync import lamp_smbus_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clock, // Destination clock
	input wire logic [WIDTH-1:0] d, // Asynchronous level
	output logic [WIDTH-1:0] q // Synchronised level
);
	logic [WIDTH-1:0] meta_q; // First stage, read only by q

	// Two flops; no reset so the chain only ever holds a port value
	always_ff @(posedge clock) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule
`default_nettype wire

// >>> design/lamp_reg_bank.sv
`default_nettype none
module lamp_reg_bank import lamp_smbus_pkg::*; (
	input wire logic clock, // System clock
	input wire logic rstn, // Synchronous reset, active low
	input wire logic commit_tgl_s, // Synchronised commit toggle
	input wire reg_sel_t wr_sel, // Held view from the link side
	input wire logic [7:0] wr_data, // Held data from the link side
	output logic [4:0] brightness_code, // Lamp brightness
	output logic [2:0] shutdown_mode_bits // Shutdown mode
);
	logic tgl_p_q; // Last seen toggle level
	wire commit_w = commit_tgl_s ^ tgl_p_q; // One pulse per commit

	// Held data are stable for the whole transaction, so a toggle edge is safe
	always_ff @(posedge clock) begin
		if (!rstn) begin
			tgl_p_q <= 1'h0;
			brightness_code <= BRIGHT_RST;
			shutdown_mode_bits <= SHDN_RST;
		end else begin
			tgl_p_q <= commit_tgl_s;
			if (commit_w) begin
				brightness_code <= next_bright(wr_sel, wr_data, brightness_code);
				shutdown_mode_bits <= next_shdn(wr_sel, wr_data, shutdown_mode_bits);
			end
		end
	end

	// Registers only move on a committed transaction
	bright_commit_a: assert property (@(posedge clock) disable iff (!rstn)
		$changed(brightness_code) |-> $past(commit_w))
		else $error("brightness changed without a commit");
	mode_commit_a: assert property (@(posedge clock) disable iff (!rstn)
		$changed(shutdown_mode_bits) |-> $past(commit_w) && $past(wr_sel) == SEL_MODE)
		else $error("shutdown mode changed without a mode commit");
endmodule
`default_nettype wire

// >>> verif/smbus_host_model.sv
`default_nettype none
module smbus_host_model (
	output logic scl, // Serial clock, driven by the host only
	output logic sda_low, // High pulls the data line low
	input wire logic sda // Resolved data line level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Quarter bit time; each clock phase far exceeds the device's sampling delay
	localparam int QTR = 100;

	// Idle bus: clock high, data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Start or repeated start; clock is low on return
	task automatic bus_start();
		sda_low = 1'b0;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_low = 1'b1;
		#QTR;
		scl = 1'b0;
		#QTR;
	endtask

	// Stop: data rises while clock is high, bus left free
	task automatic bus_stop();
		sda_low = 1'b1;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_low = 1'b0;
		#QTR;
	endtask

	// One bit: data moves in the low phase, sampled while clock is high
	task automatic bit_io(input logic b, output logic s);
		sda_low = ~b;
		#QTR;
		scl = 1'b1;
		#QTR;
		s = sda;
		#QTR;
		scl = 1'b0;
		#QTR;
	endtask

	// Byte out, most significant bit first, acknowledge on the ninth clock
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, ack);
	endtask

	// Byte in, then the host's acknowledge or not-acknowledge
	task automatic recv_byte(output logic [7:0] b, input logic mack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, b[i]);
		end
		bit_io(mack, s);
	endtask
endmodule
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench import lamp_smbus_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0; // System clock
	logic link_clock = 1'b0; // Link sampling clock
	logic rstn = 1'b0; // Reset, active low
	logic mode_strap = 1'b1; // Strap, serial mode
	logic [1:0] stat = 2'h2; // Fault status into the device
	wire scl_w; // Serial clock wire
	wire sda_w; // Resolved data wire
	wire host_low; // Host pulls data low
	wire sda_out; // Device drive value
	wire sda_oe_n; // Device enable, low drives
	wire [4:0] bright; // Brightness output
	wire [2:0] mode; // Shutdown mode output
	logic [4:0] exp_b = BRIGHT_RST; // Expected brightness
	logic [2:0] exp_m = SHDN_RST; // Expected mode
	int mismatches = 0; // Failed comparisons
	int cmp_count = 0; // All comparisons
	logic a; // Last acknowledge seen
	logic [7:0] d; // Last byte read back

	// Pulled-up line; low if either party drives it
	assign sda_w = host_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

	smbus_host_model host (.scl(scl_w), .sda_low(host_low), .sda(sda_w));

	smbus_lamp_control_slave dut (
		.clock(clock),
		.rstn(rstn),
		.link_clock(link_clock),
		.mode_strap(mode_strap),
		.level_ctl_or_serial_clock_pin(scl_w),
		.fullscale_ref_or_serial_data_pin_in(sda_w),
		.fullscale_ref_or_serial_data_pin_out(sda_out),
		.fullscale_ref_or_serial_data_pin_oe_n(sda_oe_n),
		.fault_status_bits(stat),
		.brightness_code(bright),
		.shutdown_mode_bits(mode)
	);

	// 25 MHz system clock
	initial begin
		forever #20 clock = ~clock;
	end

	// 6 ns link clock, offset so no edge lines up with the system clock
	initial begin
		#1.7;
		forever #3 link_clock = ~link_clock;
	end

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Send a byte and judge the acknowledge
	task automatic tx(input logic [7:0] b, input logic ack_exp);
		host.send_byte(b, a);
		check({7'h00, a}, {7'h00, ack_exp});
	endtask

	task automatic regs_are();
		check({mode, bright}, {exp_m, exp_b});
	endtask

	// Write byte; registers must hold until the stop
	task automatic wr(input logic [7:0] cmd, input logic [7:0] dat, input logic [4:0] nb, input logic [2:0] nm);
		host.bus_start();
		tx({OWN_ADDR, RW_WRITE}, ACK_BIT);
		tx(cmd, ACK_BIT);
		tx(dat, ACK_BIT);
		repeat (10) @(posedge clock);
		regs_are();
		host.bus_stop();
		exp_b = nb;
		exp_m = nm;
		repeat (10) @(posedge clock);
		regs_are();
	endtask

	// Start or restart, read address, one byte, not-acknowledge, stop
	task automatic rx(input logic [7:0] exp);
		host.bus_start();
		tx({OWN_ADDR, RW_READ}, ACK_BIT);
		host.recv_byte(d, NACK_BIT);
		check(d, exp);
		host.bus_stop();
	endtask

	// Read byte: command, then a repeated start inside rx
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		host.bus_start();
		tx({OWN_ADDR, RW_WRITE}, ACK_BIT);
		tx(cmd, ACK_BIT);
		rx(exp);
	endtask

	task automatic t_reset();
		regs_are();
		check({7'h00, sda_oe_n}, 8'h01);
		rx({BRIGHT_RST, COMBO_FILL, stat});
		$display("test reset done");
	endtask

	// Full scale, shutdown, minimum via combined view, read-only view
	task automatic t_write();
		wr(8'h01, 8'h1F, 5'h1F, exp_m);
		wr(8'h02, 8'h04, exp_b, 3'h4);
		wr(8'h80, 8'h07, 5'h00, exp_m);
		wr(8'h03, 8'h55, exp_b, exp_m);
		$display("test write done");
	endtask

	// Every view read while the lamp is shut down
	task automatic t_read();
		logic [7:0] cmds [8];
		logic [7:0] exps [8];
		cmds = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'hFF, 8'h82, 8'hFE};
		exps = '{{3'h0, exp_b}, {stat, MODE_FILL, exp_m}, CHIP_ID, CHIP_REV, {exp_b, COMBO_FILL, stat}, CHIP_ID,
			8'h00, MFG_ID};
		for (int i = 0; i < 8; i++) begin
			rd(cmds[i], exps[i]);
		end
		rx(MFG_ID);
		// Master acknowledge asks for the same view again
		host.bus_start();
		tx({OWN_ADDR, RW_READ}, ACK_BIT);
		host.recv_byte(d, ACK_BIT);
		check(d, MFG_ID);
		host.recv_byte(d, NACK_BIT);
		check(d, MFG_ID);
		host.bus_stop();
		$display("test read done");
	endtask

	// Send byte moves the pointer only
	task automatic t_send();
		host.bus_start();
		tx({OWN_ADDR, RW_WRITE}, ACK_BIT);
		tx(8'h01, ACK_BIT);
		host.bus_stop();
		repeat (10) @(posedge clock);
		regs_are();
		rx({3'h0, exp_b});
		$display("test send done");
	endtask

	// Neighbouring address is never acknowledged
	task automatic t_foreign();
		host.bus_start();
		tx({7'h2C, RW_WRITE}, NACK_BIT);
		tx(8'h01, NACK_BIT);
		tx(8'h1F, NACK_BIT);
		host.bus_stop();
		repeat (10) @(posedge clock);
		regs_are();
		$display("test foreign done");
	endtask

	// Data cut short by a stop, then by a restart
	task automatic t_abort();
		host.bus_start();
		tx({OWN_ADDR, RW_WRITE}, ACK_BIT);
		tx(8'h01, ACK_BIT);
		for (int i = 0; i < 4; i++) begin
			host.bit_io(1'b1, a);
		end
		host.bus_stop();
		repeat (10) @(posedge clock);
		regs_are();
		host.bus_start();
		tx({OWN_ADDR, RW_WRITE}, ACK_BIT);
		tx(8'h02, ACK_BIT);
		for (int i = 0; i < 3; i++) begin
			host.bit_io(1'b1, a);
		end
		rx({3'h0, exp_b});
		regs_are();
		$display("test abort done");
	endtask

	// Strap low keeps the line released; status follows its input
	task automatic t_strap();
		@(posedge clock);
		mode_strap <= 1'b0;
		repeat (10) @(posedge clock);
		host.bus_start();
		tx({OWN_ADDR, RW_WRITE}, NACK_BIT);
		host.bus_stop();
		@(posedge clock);
		mode_strap <= 1'b1;
		stat <= 2'h1;
		repeat (10) @(posedge clock);
		rd(8'h02, {2'h1, MODE_FILL, exp_m});
		$display("test strap done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (10) @(posedge clock);
		t_reset();
		t_write();
		t_read();
		t_send();
		t_foreign();
		t_abort();
		t_strap();
		complete_run();
	end

	// Watchdog, about four times the expected run
	initial begin
		repeat (30000) @(posedge clock);
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire
